// ### design/pvic_defs.vh
// Constants for the priority vectored interrupt controller
// Assumes inclusion by the controller files only
`ifndef PVIC_DEFS_VH
`define PVIC_DEFS_VH
`define PVIC_NSRC          17
`define PVIC_ENABLE_ADDR   8'ha8
`define PVIC_ENABLE_RST    8'h00
`define PVIC_GATE_BIT      7
`define PVIC_VEC_BASE      16'h0003
`define PVIC_VEC_STEP      16'h0008
`define PVIC_VEC_RESET     16'h0000
`define PVIC_ORD_EXT0      0
`define PVIC_ORD_T0        1
`define PVIC_ORD_EXT1      2
`define PVIC_ORD_T1        3
`define PVIC_ORD_UART      4
`define PVIC_ORD_T2        5
`define PVIC_ORD_SPI       6
`define PVIC_ORD_RSVD      13
`define PVIC_DETECT_CYC    1
`define PVIC_CALL_CYC      4
`define PVIC_ST_IDLE       2'h0
`define PVIC_ST_REQ        2'h1
`define PVIC_ST_HOLD       2'h2
`endif

// ### design/pvic_arbiter.v
// Fixed order arbiter: lowest index among requests wins
// Assumes requests are already gated and level filtered
`timescale 1ns/1ns
module pvic_arbiter #(
  parameter N  = 17,
  parameter IW = 5
) (
  input  wire [N-1:0]  req,
  output reg           any,
  output reg  [IW-1:0] idx
);
  integer i;
  always @*
  begin
    any = 1'b0;
    idx = {IW{1'b0}};
    for (i = N - 1; i >= 0; i = i - 1)
    begin
      if (req[i])
      begin
        any = 1'b1;
        idx = i[IW-1:0];
      end
    end
  end
endmodule

// ### design/pvic_top.v
// Two level vectored interrupt controller with fixed order arbitration
// Assumes a CPU that pulses boundary, ack and return-done signals
// Behaviour
// - Seventeen sources feed the controller
// - Software-set flags request like hardware flags
// - One level bit per source, reset low
// - High preempts low; high never preempted
// - High level wins over low level
// - Equal level resolved by fixed source order
// - Requests evaluated every clock cycle
// - Request detected one cycle, call four
// - One instruction after return before call
// - Worst case eighteen clocks response
// - Equal or higher handler blocks new request
// - Fixed vector per source, step eight
// - Bit seven gates all sources
// - Enable register at 0xa8, reset zero
// - Enable bits six to zero per source
// - Timer two passes either overflow flag
// - Vectoring clears ext and timer0/1 flags
// - Masked flags make no request
// - Flag left set re-requests after return
`timescale 1ns/1ns
`include "pvic_defs.vh"
module pvic_top #(
  parameter NSRC = `PVIC_NSRC,
  parameter IW   = 5
) (
  input  wire            mclk,
  input  wire            reset,
  input  wire [7:0]      reg_addr,
  input  wire [7:0]      reg_wdata,
  input  wire            reg_wr,
  input  wire            reg_bit_wr,
  input  wire [2:0]      reg_bit_sel,
  input  wire            reg_bit_val,
  input  wire            reg_rd,
  output reg  [7:0]      reg_rdata_ff,
  input  wire [NSRC-1:0] pending_flags,
  input  wire            timer2_low_overflow_flag,
  input  wire            timer2_high_overflow_flag,
  input  wire [NSRC-1:0] ext_enable,
  input  wire [NSRC-1:0] irq_level_primary,
  input  wire            insn_boundary,
  input  wire            cpu_ack,
  input  wire            reti_done,
  output reg             irq_req_ff,
  output reg  [15:0]     irq_vector_ff,
  output reg  [3:0]      auto_clear_ff,
  output reg  [1:0]      in_service_ff
);
  reg  [7:0]      irq_enable_primary_ff;
  reg  [7:0]      nxt_enable;
  reg  [1:0]      state_ff;
  reg  [1:0]      nxt_state;
  reg  [IW-1:0]   sel_ff;
  reg             sel_high_ff;
  reg  [NSRC-1:0] unmask;
  reg  [NSRC-1:0] flags;
  wire            global_irq_gate;
  wire [NSRC-1:0] active;
  wire [NSRC-1:0] hi_req;
  wire [NSRC-1:0] lo_req;
  wire            hi_any;
  wire            lo_any;
  wire [IW-1:0]   hi_idx;
  wire [IW-1:0]   lo_idx;
  wire            hi_ok;
  wire            lo_ok;
  wire            win_any;
  wire [IW-1:0]   win_idx;
  wire            win_high;
  wire [15:0]     win_vec;

  // Register write path, byte or single bit
  always @*
  begin
    nxt_enable = irq_enable_primary_ff;
    if (reg_wr && reg_addr == `PVIC_ENABLE_ADDR)
      nxt_enable = reg_wdata;
    else if (reg_bit_wr && reg_addr == `PVIC_ENABLE_ADDR)
      nxt_enable[reg_bit_sel] = reg_bit_val;
  end

  always @(posedge mclk)
  begin
    if (reset)
    begin
      irq_enable_primary_ff <= `PVIC_ENABLE_RST;
      reg_rdata_ff          <= 8'h00;
    end
    else
    begin
      irq_enable_primary_ff <= nxt_enable;
      if (reg_rd && reg_addr == `PVIC_ENABLE_ADDR)
        reg_rdata_ff <= irq_enable_primary_ff;
      else
        reg_rdata_ff <= 8'h00;
    end
  end

  assign global_irq_gate = irq_enable_primary_ff[`PVIC_GATE_BIT];

  // Per-source unmask selection
  always @*
  begin
    unmask = ext_enable;
    unmask[`PVIC_ORD_EXT0] = irq_enable_primary_ff[0];
    unmask[`PVIC_ORD_T0]   = irq_enable_primary_ff[1];
    unmask[`PVIC_ORD_EXT1] = irq_enable_primary_ff[2];
    unmask[`PVIC_ORD_T1]   = irq_enable_primary_ff[3];
    unmask[`PVIC_ORD_UART] = irq_enable_primary_ff[4];
    unmask[`PVIC_ORD_T2]   = irq_enable_primary_ff[5];
    unmask[`PVIC_ORD_SPI]  = irq_enable_primary_ff[6];
    unmask[`PVIC_ORD_RSVD] = 1'b0;
    flags = pending_flags;
    flags[`PVIC_ORD_T2] = timer2_low_overflow_flag | timer2_high_overflow_flag;
  end

  // Masked flags drop out here
  assign active = global_irq_gate ? (flags & unmask) : {NSRC{1'b0}};
  assign hi_req = active & irq_level_primary;
  assign lo_req = active & ~irq_level_primary;

  pvic_arbiter #(
    .N  (NSRC),
    .IW (IW)
  ) u_hi_arb (
    .req (hi_req),
    .any (hi_any),
    .idx (hi_idx)
  );

  pvic_arbiter #(
    .N  (NSRC),
    .IW (IW)
  ) u_lo_arb (
    .req (lo_req),
    .any (lo_any),
    .idx (lo_idx)
  );

  // High may run unless a high handler is in service
  assign hi_ok    = hi_any && !in_service_ff[1];
  // Low may run only when nothing is in service
  assign lo_ok    = lo_any && (in_service_ff == 2'b00);
  assign win_any  = hi_ok || lo_ok;
  assign win_high = hi_ok;
  assign win_idx  = hi_ok ? hi_idx : lo_idx;
  assign win_vec  = `PVIC_VEC_BASE + {{(16-IW){1'b0}}, win_idx} * `PVIC_VEC_STEP;

  // Request sequencing around boundaries and returns
  always @*
  begin
    nxt_state = state_ff;
    case (state_ff)
      `PVIC_ST_IDLE:
        if (win_any && insn_boundary)
          nxt_state = `PVIC_ST_REQ;
      `PVIC_ST_REQ:
        if (cpu_ack)
          nxt_state = `PVIC_ST_IDLE;
        else if (!win_any)
          nxt_state = `PVIC_ST_IDLE;
      `PVIC_ST_HOLD:
        if (insn_boundary && win_any)
          nxt_state = `PVIC_ST_REQ;
        else if (insn_boundary)
          nxt_state = `PVIC_ST_IDLE;
      default:
        nxt_state = `PVIC_ST_IDLE;
    endcase
    if (reti_done)
      nxt_state = `PVIC_ST_HOLD;
  end

  always @(posedge mclk)
  begin
    if (reset)
    begin
      state_ff      <= `PVIC_ST_IDLE;
      irq_req_ff    <= 1'b0;
      irq_vector_ff <= `PVIC_VEC_RESET;
      auto_clear_ff <= 4'h0;
      in_service_ff <= 2'b00;
      sel_ff        <= {IW{1'b0}};
      sel_high_ff   <= 1'b0;
    end
    else
    begin
      state_ff      <= nxt_state;
      auto_clear_ff <= 4'h0;
      if (nxt_state == `PVIC_ST_REQ)
      begin
        irq_req_ff    <= 1'b1;
        irq_vector_ff <= win_vec;
        sel_ff        <= win_idx;
        sel_high_ff   <= win_high;
      end
      else
        irq_req_ff <= 1'b0;
      if (state_ff == `PVIC_ST_REQ && cpu_ack)
      begin
        // Hardware clears for ext and timer 0/1 on vectoring
        auto_clear_ff[0] <= sel_ff == `PVIC_ORD_EXT0;
        auto_clear_ff[1] <= sel_ff == `PVIC_ORD_T0;
        auto_clear_ff[2] <= sel_ff == `PVIC_ORD_EXT1;
        auto_clear_ff[3] <= sel_ff == `PVIC_ORD_T1;
        if (sel_high_ff)
          in_service_ff[1] <= 1'b1;
        else
          in_service_ff[0] <= 1'b1;
      end
      else if (reti_done)
      begin
        // Most recent marker goes first
        if (in_service_ff[1])
          in_service_ff[1] <= 1'b0;
        else
          in_service_ff[0] <= 1'b0;
      end
    end
  end
endmodule

// ### tb/pvic_assertions.sv
// Checker for the interrupt controller top
// Assumes binding to pvic_top; sees its ports only
`timescale 1ns/1ns
module pvic_checker (
  input wire        mclk,
  input wire        reset,
  input wire [7:0]  reg_addr,
  input wire        reg_rd,
  input wire [7:0]  reg_rdata_ff,
  input wire        insn_boundary,
  input wire        cpu_ack,
  input wire        reti_done,
  input wire        irq_req_ff,
  input wire [15:0] irq_vector_ff,
  input wire [3:0]  auto_clear_ff,
  input wire [1:0]  in_service_ff
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);
  vec_grid_a: assert property (
    irq_req_ff |-> irq_vector_ff[2:0] == 3'h3 && irq_vector_ff <= 16'h0083)
    else $error("Vector off grid");
  read_zero_a: assert property (
    !$past(reg_rd) || $past(reg_addr) != 8'ha8 |-> reg_rdata_ff == 8'h00)
    else $error("Read data not zero");
  high_blocks_a: assert property (
    $rose(irq_req_ff) |-> !$past(in_service_ff[1])) else $error("High handler preempted");
  rise_boundary_a: assert property (
    $rose(irq_req_ff) |-> $past(insn_boundary)) else $error("Request off boundary");
  ack_done_a: assert property (
    cpu_ack && irq_req_ff |=> !irq_req_ff && in_service_ff != 2'h0)
    else $error("Ack not taken");
  reti_wait_a: assert property (
    reti_done |=> !$rose(irq_req_ff)) else $error("Request right after return");
  clear_pulse_a: assert property (
    auto_clear_ff != 4'h0 |=> auto_clear_ff == 4'h0) else $error("Clear pulse too long");
  clear_cause_a: assert property (
    auto_clear_ff != 4'h0 |-> $past(cpu_ack) && $onehot(auto_clear_ff))
    else $error("Clear without ack");
  cover property ($rose(irq_req_ff));
  cover property (in_service_ff == 2'h3);
  cover property (reti_done && in_service_ff == 2'h1);
endmodule
bind pvic_top pvic_checker pvic_checker_inst (.*);

// ### tb/pvic_cpu_model.sv
// CPU sequencer model: instruction boundaries, ack, return
// Assumes the bench commands each return-from-interrupt
`timescale 1ns/1ns
module pvic_cpu_model #(
  parameter GAP = 3
) (
  input wire mclk,
  input wire reset,
  input wire irq_req_ff,
  input wire reti_cmd,
  output reg insn_boundary,
  output reg cpu_ack,
  output reg reti_done
);
  reg [3:0] cnt_ff;
  always @(posedge mclk)
  begin
    reti_done <= reti_cmd & ~reset;
    cpu_ack <= irq_req_ff & ~cpu_ack & ~reset;
    insn_boundary <= ~reset & ~reti_cmd & (cnt_ff == GAP - 1);
    if (reset || reti_cmd || cnt_ff == GAP - 1)
      cnt_ff <= 4'h0;
    else
      cnt_ff <= cnt_ff + 4'h1;
  end
endmodule

// ### tb/tb_pvic_top.sv
// Bench for the interrupt controller
// Assumes the CPU model answers every request
`timescale 1ns/1ns
module tb_pvic_top;
  reg mclk = 0, reset = 1, reg_wr = 0, reg_bit_wr = 0, reg_bit_val = 0, reg_rd = 0;
  reg t2l = 0, t2h = 0, reti_cmd = 0;
  reg [7:0] reg_addr = 0, reg_wdata = 0;
  reg [2:0] reg_bit_sel = 0;
  reg [16:0] pf = 0, ee = 0, lv = 0;
  wire insn_boundary, cpu_ack, reti_done, irq_req_ff;
  wire [15:0] irq_vector_ff;
  wire [7:0] reg_rdata_ff;
  wire [3:0] auto_clear_ff;
  wire [1:0] in_service_ff;
  integer error_cnt = 0, samples_checked = 0, i, n;
  always #50 mclk = ~mclk;
  pvic_top pvic_top_inst (.*, .pending_flags(pf), .timer2_low_overflow_flag(t2l),
    .timer2_high_overflow_flag(t2h), .ext_enable(ee), .irq_level_primary(lv));
  pvic_cpu_model pvic_cpu_model_inst (.*);
  task tick;
  begin
    @(posedge mclk);
    #1;
  end
  endtask
  task conclude;
  begin
    $display("Checks %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  end
  endtask
  task chk(input ok);
  begin
    samples_checked = samples_checked + 1;
    if (!ok)
    begin
      error_cnt = error_cnt + 1;
      $display("Error at %0t: mismatch", $time);
    end
  end
  endtask
  task wr(input [7:0] a, input [7:0] d);
  begin
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1;
    tick;
    reg_wr <= 0;
  end
  endtask
  task rd(input [7:0] a, input [7:0] e);
  begin
    reg_addr <= a;
    reg_rd <= 1;
    tick;
    reg_rd <= 0;
    chk(reg_rdata_ff === e);
  end
  endtask
  task svc(input [15:0] v, input [3:0] ac);
  begin
    for (n = 0; n < 40 && irq_req_ff !== 1'b1; n = n + 1) tick;
    if (n == 40) begin chk(0); conclude; end
    chk(irq_vector_ff === v);
    for (n = 0; n < 9 && cpu_ack !== 1'b1; n = n + 1) tick;
    if (n == 9) begin chk(0); conclude; end
    tick;
    chk(auto_clear_ff === ac && irq_req_ff === 1'b0);
  end
  endtask
  task reti;
  begin
    reti_cmd <= 1;
    tick;
    reti_cmd <= 0;
    tick;
  end
  endtask
  initial
  begin
    repeat (12) tick;
    reset <= 0;
    tick;
    rd(8'ha8, 8'h00);
    wr(8'ha8, 8'hff);
    reg_bit_sel <= 3'h7;
    reg_bit_wr <= 1;
    tick;
    reg_bit_wr <= 0;
    rd(8'ha8, 8'h7f);
    rd(8'h11, 8'h00);
    pf <= 17'h1;
    repeat (10) tick;
    chk(irq_req_ff === 1'b0);
    for (i = 0; i < 7; i = i + 1)
    begin
      pf <= (i == 5) ? 17'h0 : 17'h1 << i;
      t2h <= (i == 5);
      wr(8'ha8, 8'h80 | (8'h1 << i));
      svc(16'h3 + 8 * i, (i < 4) ? 4'h1 << i : 4'h0);
      pf <= 0;
      t2h <= 0;
      reti;
    end
    lv <= 17'h8;
    pf <= 17'ha;
    wr(8'ha8, 8'h8f);
    svc(16'h1b, 4'h8);
    pf <= 17'h2;
    reti;
    svc(16'h0b, 4'h2);
    pf <= 17'h8;
    svc(16'h1b, 4'h8);
    chk(in_service_ff === 2'h3);
    pf <= 0;
    reti;
    reti;
    chk(in_service_ff === 2'h0);
    lv <= 0;
    ee <= 17'h10000;
    pf <= 17'h10000;
    wr(8'ha8, 8'h80);
    svc(16'h0083, 4'h0);
    pf <= 0;
    ee <= 0;
    reti;
    pf <= 17'h6;
    wr(8'ha8, 8'h87);
    svc(16'h000b, 4'h2);
    conclude;
  end
endmodule
